// >>> rtl/tkw_cfg.svh
// constants for the ticket write and counter command interpreter
// assumes a byte stream from the frame decoder with an end mark but no start mark
`ifndef TKW_CFG_SVH
`define TKW_CFG_SVH
`define TKW_OP_WRITE      8'hA2
`define TKW_OP_COMPAT     8'hA0
`define TKW_OP_RD_CNT     8'h39
`define TKW_OP_INC_CNT    8'hA5
`define TKW_PAGE_MIN      8'h02
`define TKW_PAGE_MAX_S    8'h13
`define TKW_PAGE_MAX_L    8'h28
`define TKW_PAGE_XLOCK    8'h24
`define TKW_CNT_MAX_IDX   8'h02
`define TKW_CNT_FULL      24'hFFFFFF
`define TKW_ACK           4'hA
`define TKW_NAK           4'h0
`define TKW_NAK_MIN_BITS  9
`define TKW_BIT_NS        9440
`define TKW_CLK_NS        8
`define TKW_TURN_CYC      ((`TKW_NAK_MIN_BITS*`TKW_BIT_NS+`TKW_CLK_NS-1)/`TKW_CLK_NS)
`endif

// >>> rtl/tkw_pkg.sv
// types of the ticket write and counter command interpreter
// used only by tkw_core
package tkw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RECV   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_WAIT   = 3'b011,
    ST_REPLY  = 3'b100
  } tkw_state_e;

  typedef struct packed {
    tkw_state_e  st;
    logic [7:0][7:0] buf_b;
  } tkw_dummy_s;
endpackage : tkw_pkg

// >>> rtl/tkw_core.sv
// command interpreter for page writes and the three one-way counters
// assumes: rx bytes already stripped of parity, crc_ok valid the cycle after the end mark,
// page memory external with a write port and lock map input
`timescale 1ns/10ps
`include "tkw_cfg.svh"

module tkw_core
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // receive byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_ok,
  // configuration and session state
  input  wire logic        large_variant,
  input  wire logic        authenticated,
  input  wire logic        prot_enable,
  input  wire logic [7:0]  protection_start_page,
  input  wire logic [63:0] page_locked,
  // page memory write port
  output logic             mem_we,
  output logic [7:0]       mem_page,
  output logic [31:0]      mem_wdata,
  output logic             mem_atomic,
  // answer
  output logic             tx_nibble_valid,
  output logic [3:0]       tx_nibble,
  output logic             tx_data_valid,
  output logic [23:0]      tx_data,
  output logic [71:0]      cnt_value
);

  // ==========================================================
  // state
  typedef struct packed {
    tkw_pkg::tkw_state_e st;
    logic [4:0]          idx;
    logic [7:0]          op;
    logic [7:0]          arg;
    logic [31:0]         pay;
    logic                compat2;
    logic [7:0]          cpage;
    logic [15:0]         tcnt;
    logic [3:0]          ans;
    logic                ans_data;
    logic [23:0]         rdat;
    logic                we;
    logic [71:0]         cnt;
  } tkw_state_s;

  tkw_state_s q, d;

  // page acceptance check shared by both write forms
  function automatic logic page_ok(input logic [7:0] p, input logic lg,
                                   input logic au, input logic pe,
                                   input logic [7:0] ps,
                                   input logic [63:0] lk);
    logic [7:0] hi;
    hi = lg ? `TKW_PAGE_MAX_L : `TKW_PAGE_MAX_S;
    page_ok = (p >= `TKW_PAGE_MIN) && (p <= hi)
              && !lk[p[5:0]]
              && !(pe && !au && (p >= ps));
  endfunction : page_ok

  // counter number decode shared by the read and increment paths;
  // anything above the last counter is refused; sel_cnt is still formed from its low two bits
  function automatic logic cnt_sel_ok(input logic [7:0] n);
    cnt_sel_ok = (n <= `TKW_CNT_MAX_IDX);
  endfunction : cnt_sel_ok

  logic [23:0] sel_cnt;
  logic [24:0] sum;
  logic [1:0]  ci;

  // ==========================================================
  // next state
  // one frame is collected byte by byte, judged in a single cycle
  // once the frame ends, and the answer is then held back for the
  // minimum turnaround before it is offered to the transmitter.
  // the second part of a legacy write is recognised only by the
  // pending flag left by an accepted first part; a reader that
  // abandons the sequence gets its next frame read as payload,
  // which is then refused for its wrong length.
  always_comb
  begin
    d       = q;
    d.we    = 1'b0;
    ci      = q.arg[1:0];
    // counter number 3 has no counter behind it; read zero instead of
    // indexing past the end of the counter bank
    if (ci == 2'h3)
      sel_cnt = 24'h000000;
    else
      sel_cnt = q.cnt[ci*24 +: 24];
    sum     = {1'b0, sel_cnt} + {1'b0, q.pay[23:0]};
    unique case (q.st)
      tkw_pkg::ST_IDLE:
      begin
        if (rx_valid)
        begin
          d.idx = 5'h1;
          d.st  = tkw_pkg::ST_RECV;
          if (q.compat2)
            d.pay = {24'h000000, rx_byte};
          else
            d.op = rx_byte;
        end
      end
      tkw_pkg::ST_RECV:
      begin
        if (rx_valid)
        begin
          d.idx = q.idx + 5'h1;
          // second legacy part: keep bytes 0..3, drop 4..15
          if (q.compat2 && q.idx < 5'h4)
            d.pay[q.idx[1:0]*8 +: 8] = rx_byte;
          else if (!q.compat2 && q.idx == 5'h1)
            d.arg = rx_byte;
          else if (!q.compat2 && q.idx >= 5'h2 && q.idx <= 5'h5)
            d.pay[(q.idx[2:0]-3'h2)*8 +: 8] = rx_byte;
        end
        if (rx_end)
          d.st = tkw_pkg::ST_EXEC;
      end
      tkw_pkg::ST_EXEC:
      begin
        d.ans      = `TKW_NAK;
        d.ans_data = 1'b0;
        d.tcnt     = 16'h0000;
        d.st       = tkw_pkg::ST_WAIT;
        if (!rx_crc_ok)
          d.compat2 = 1'b0;
        else if (q.compat2)
        begin
          d.compat2 = 1'b0;
          if (q.idx == 5'h10)
          begin
            d.we  = 1'b1;
            d.ans = `TKW_ACK;
          end
        end
        else
          unique case (q.op)
            `TKW_OP_WRITE:
              if (page_ok(q.arg, large_variant, authenticated, prot_enable,
                          protection_start_page, page_locked))
              begin
                d.we    = 1'b1;
                d.cpage = q.arg;
                d.ans   = `TKW_ACK;
              end
            `TKW_OP_COMPAT:
              if (page_ok(q.arg, large_variant, authenticated, prot_enable,
                          protection_start_page, page_locked))
              begin
                d.compat2 = 1'b1;
                d.cpage   = q.arg;
                d.ans     = `TKW_ACK;
              end
            `TKW_OP_RD_CNT:
              if (cnt_sel_ok(q.arg))
              begin
                d.rdat     = sel_cnt;
                d.ans_data = 1'b1;
              end
            `TKW_OP_INC_CNT:
              // the carry out of the 24-bit sum marks an increment past
              // the final value; the counter is then left as it was
              if (cnt_sel_ok(q.arg) && !sum[24])
              begin
                d.cnt[ci*24 +: 24] = sum[23:0];
                d.ans              = `TKW_ACK;
              end
            default:
              d.ans = `TKW_NAK;
          endcase
      end
      tkw_pkg::ST_WAIT:
      begin
        // hold the answer for the minimum turnaround; the count is a
        // fixed number of cycles, so a faster clock needs a new
        // constant or the answer comes too early
        d.tcnt = q.tcnt + 16'h0001;
        if (q.tcnt >= 16'(`TKW_TURN_CYC - 1))
          d.st = tkw_pkg::ST_REPLY;
      end
      tkw_pkg::ST_REPLY:
        d.st = tkw_pkg::ST_IDLE;
      default:
        d.st = tkw_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  // counters live here and are cleared by reset only; keeping them
  // in non-volatile storage is left to the surrounding memory
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      q       <= '0;
      q.st    <= tkw_pkg::ST_IDLE;
      q.cnt   <= 72'h0;
    end
    else
      q <= d;
  end

  // ==========================================================
  // outputs; the store is one write of the whole page so torn
  // updates of lock and otp pages cannot occur
  assign mem_we          = q.we;
  assign mem_page        = q.cpage;
  assign mem_wdata       = q.pay;
  assign mem_atomic      = (q.cpage == 8'h02) || (q.cpage == 8'h03)
                           || (large_variant && q.cpage == `TKW_PAGE_XLOCK);
  // answer strobes last exactly the one reply cycle; the values
  // behind them stay until the next answer overwrites them
  assign tx_nibble_valid = (q.st == tkw_pkg::ST_REPLY) && !q.ans_data;
  assign tx_nibble       = q.ans;
  assign tx_data_valid   = (q.st == tkw_pkg::ST_REPLY) && q.ans_data;
  assign tx_data         = q.rdat;
  assign cnt_value       = q.cnt;

endmodule : tkw_core

// >>> testbench/tkw_core_monitor.sv
// port checker for tkw_core
// bound to each tkw_core; one clock, synchronous reset
`timescale 1ns/10ps
`include "tkw_cfg.svh"
module tkw_core_monitor
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // request and session
  input wire logic        rx_end,
  input wire logic        rx_crc_ok,
  input wire logic        large_variant,
  input wire logic        authenticated,
  input wire logic        prot_enable,
  input wire logic [7:0]  protection_start_page,
  input wire logic [63:0] page_locked,
  // write port and answer
  input wire logic        mem_we,
  input wire logic [7:0]  mem_page,
  input wire logic        mem_atomic,
  input wire logic        tx_nibble_valid
);
  logic [13:0] gap_q;
  // ====
  // cycles since frame end; saturates so an idle link never wraps
  always_ff @(posedge ref_clk)
    if (sys_rst)
      gap_q <= 14'h3FFF;
    else if (rx_end)
      gap_q <= 14'h0001;
    else if (gap_q != 14'h3FFF)
      gap_q <= gap_q + 14'h0001;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_TURN: assert property (tx_nibble_valid |-> gap_q >= `TKW_TURN_CYC
    && gap_q <= `TKW_TURN_CYC + 2) else $error("answer off time");
  AST_NIB_PULSE: assert property (tx_nibble_valid |=> !tx_nibble_valid)
    else $error("answer too long");
  AST_WE_CAUSE: assert property (mem_we |-> $past(rx_end, 2)
    && $past(rx_crc_ok)) else $error("write without good frame");
  AST_WE_ONE: assert property (mem_we |=> !mem_we [*3])
    else $error("write repeated");
  AST_RANGE: assert property (mem_we |-> mem_page >= `TKW_PAGE_MIN &&
    mem_page <= (large_variant ? `TKW_PAGE_MAX_L : `TKW_PAGE_MAX_S))
    else $error("page out of range");
  AST_LOCK: assert property (mem_we |-> !page_locked[mem_page[5:0]])
    else $error("locked page written");
  AST_PROT: assert property (mem_we && prot_enable && !authenticated
    |-> mem_page < protection_start_page) else $error("protected page");
  AST_ATOM: assert property (mem_we |-> mem_atomic == (mem_page == 8'h02
    || mem_page == 8'h03 || large_variant && mem_page == `TKW_PAGE_XLOCK))
    else $error("atomic flag wrong");
endmodule : tkw_core_monitor
bind tkw_core tkw_core_monitor u_tkw_core_monitor (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
  .large_variant(large_variant), .authenticated(authenticated),
  .prot_enable(prot_enable), .page_locked(page_locked),
  .protection_start_page(protection_start_page), .mem_we(mem_we),
  .mem_page(mem_page), .mem_atomic(mem_atomic),
  .tx_nibble_valid(tx_nibble_valid));

// >>> testbench/tkw_reader.sv
// reader model: one request frame, a byte per cycle
// driven after rising edges; bench calls send and waits
`timescale 1ns/10ps
module tkw_reader
(
  // clock
  input wire logic  ref_clk,
  // byte stream
  output logic       rx_valid,
  output logic [7:0] rx_byte,
  output logic       rx_end,
  output logic       rx_crc_ok
);
  // ====
  // idle line at power up
  initial
  begin
    rx_valid  = 1'b0;
    rx_byte   = 8'h00;
    rx_end    = 1'b0;
    rx_crc_ok = 1'b0;
  end
  // low byte first; crc verdict stands a cycle past the end mark
  task send(input int n, input logic ok, input logic [127:0] f);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte  <= f[8*i +: 8];
    end
    @(posedge ref_clk);
    rx_valid  <= 1'b0;
    rx_byte   <= ~rx_byte;
    rx_end    <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge ref_clk);
    rx_end <= 1'b0;
    @(posedge ref_clk);
    rx_crc_ok <= 1'b0;
  endtask : send
endmodule : tkw_reader

// >>> testbench/tkw_core_tb.sv
// bench for tkw_core with the reader model
// each answer takes about 10.6k cycles, so few frames fit
`timescale 1ns/10ps
`include "tkw_cfg.svh"
module tkw_core_tb;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        large_variant = 1'b0;
  logic        authenticated = 1'b0;
  logic        prot_enable = 1'b0;
  logic [7:0]  protection_start_page = 8'hFF;
  logic [63:0] page_locked = 64'h0;
  logic        rx_valid, rx_end, rx_crc_ok, mem_we, mem_atomic, we_seen;
  logic        tx_nibble_valid, tx_data_valid;
  logic [7:0]  rx_byte, mem_page, we_pg;
  logic [31:0] mem_wdata, we_dat;
  logic [3:0]  tx_nibble;
  logic [23:0] tx_data;
  logic [71:0] cnt_value;
  int          n_tests = 0;
  int          err_total = 0;
  always #4 ref_clk = ~ref_clk;
  // keep the last write; the strobe lasts one cycle only
  always @(posedge ref_clk)
    if (mem_we === 1'b1)
    begin
      we_seen <= 1'b1;
      we_pg   <= mem_page;
      we_dat  <= mem_wdata;
    end
  tkw_reader u_tkw_reader (.ref_clk(ref_clk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok));
  tkw_core u_tkw_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .large_variant(large_variant),
    .authenticated(authenticated), .prot_enable(prot_enable),
    .protection_start_page(protection_start_page),
    .page_locked(page_locked), .mem_we(mem_we), .mem_page(mem_page),
    .mem_wdata(mem_wdata), .mem_atomic(mem_atomic),
    .tx_nibble_valid(tx_nibble_valid), .tx_nibble(tx_nibble),
    .tx_data_valid(tx_data_valid), .tx_data(tx_data),
    .cnt_value(cnt_value));
  // ====
  task final_report;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one frame, bounded wait for its answer, then judge it
  task xfer(input int n, input logic ok, input logic [127:0] f,
            input logic [3:0] nib, input logic dv, input logic w);
    int k;
    we_seen = 1'b0;
    u_tkw_reader.send(n, ok, f);
    for (k = 0; k < 12000 && (tx_nibble_valid | tx_data_valid) !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 12000)
    begin
      err_total++;
      $display("BAD answer expected 1 seen 0");
      final_report();
    end
    if (dv)
      chk("data_valid", 1, tx_data_valid);
    else
      chk("nibble", {1'b1, nib}, {tx_nibble_valid, tx_nibble});
    chk("write", w, we_seen);
  endtask : xfer
  // ====
  task t_prot;
    @(posedge ref_clk);
    prot_enable <= 1'b1;
    protection_start_page <= 8'h05;
    xfer(6, 1'b1, 64'h4433_2211_05A2, `TKW_NAK, 1'b0, 1'b0);
  endtask : t_prot
  task t_write;
    xfer(6, 1'b1, 64'h4433_2211_04A2, `TKW_ACK, 1'b0, 1'b1);
    chk("page", 8'h04, we_pg);
    chk("wdata", 32'h4433_2211, we_dat);
  endtask : t_write
  task t_range;
    xfer(6, 1'b1, 64'h4433_2211_14A2, `TKW_NAK, 1'b0, 1'b0);
  endtask : t_range
  task t_lock;
    @(posedge ref_clk);
    protection_start_page <= 8'hFF;
    page_locked <= 64'h40;
    xfer(6, 1'b1, 64'h4433_2211_06A2, `TKW_NAK, 1'b0, 1'b0);
  endtask : t_lock
  task t_incr;
    xfer(6, 1'b1, 64'hFF00_0005_01A5, `TKW_ACK, 1'b0, 1'b0);
    chk("counter1", 24'h5, cnt_value[47:24]);
  endtask : t_incr
  task t_read;
    xfer(2, 1'b1, 64'h0139, `TKW_ACK, 1'b1, 1'b0);
    chk("count", 24'h5, tx_data);
    xfer(2, 1'b1, 64'h0339, `TKW_NAK, 1'b0, 1'b0);
  endtask : t_read
  task t_crc;
    xfer(6, 1'b0, 64'h4433_2211_04A2, `TKW_NAK, 1'b0, 1'b0);
  endtask : t_crc
  task t_auth;
    @(posedge ref_clk);
    authenticated <= 1'b1;
    large_variant <= 1'b1;
    protection_start_page <= 8'h05;
    xfer(2, 1'b1, 64'h28A0, `TKW_ACK, 1'b0, 1'b0);
    xfer(16, 1'b1, 128'hDDCC_BBAA, `TKW_ACK, 1'b0, 1'b1);
    chk("page", 8'h28, we_pg);
    chk("wdata", 32'hDDCC_BBAA, we_dat);
  endtask : t_auth
  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_prot();
    t_write();
    t_range();
    t_lock();
    t_incr();
    t_read();
    t_crc();
    t_auth();
    final_report();
  end
endmodule : tkw_core_tb
